// ### test/lane_clk_ctrl_checker.sv
// Port-level assertions for the lane clocking control block.
// Assumes one clock domain and a synchronous active-high reset.
module lane_clk_ctrl_checker
   import lane_clk_pkg::*;
#(parameter int LANES = NUM_LANES, parameter int PHASE_W = PHASE_BITS) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [11:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire synth_status_t synth_status,
   input wire logic [LANES-1:0] lane_early,
   input wire logic [LANES-1:0] lane_late,
   input wire clk_ctrl_t clk_ctrl,
   input wire logic [LANES-1:0] lane_rx_enable,
   input wire logic [LANES*PHASE_W-1:0] lane_phase,
   input wire logic irq
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   // Register accesses; derived outputs follow a write by two edges
   sequence s_wr(logic [11:0] a);
      reg_wr && reg_addr == a;
   endsequence
   sequence s_rd(logic [11:0] a);
      reg_rd && reg_addr == a;
   endsequence
   // Two clean edges since reset, so reset values have been replaced
   sequence s_run;
      !$past(sys_rst) && !$past(sys_rst, 2);
   endsequence
   a_lane_off: assert property (
      s_wr(ADDR_LANE_PD) |-> ##2 (lane_rx_enable & $past(reg_wdata, 2)) == 0)
      else $error("masked lane still enabled");
   a_eq_mode: assert property (
      s_wr(ADDR_EQ_CONFIG) |-> ##2 clk_ctrl.eq_low_power ==
      ($past(reg_wdata[7:6], 2) == EQ_LOW_POWER))
      else $error("equalizer power mode wrong");
   a_synth_enable: assert property (
      s_wr(ADDR_SYNTH_CTRL) |-> ##2
      clk_ctrl.synth_enable == $past(reg_wdata[0], 2))
      else $error("synthesizer enable wrong");
   // The restart pulse is launched by the write edge itself, one edge
   // ahead of the other derived controls
   a_recal_pulse: assert property (
      clk_ctrl.cal_restart |-> $past(reg_wr) && $past(reg_wdata[2])
      && $past(reg_addr) == ADDR_SYNTH_CTRL ##1 !clk_ctrl.cal_restart)
      else $error("calibration restart pulse wrong");
   a_quad_const: assert property (
      s_run |-> clk_ctrl.quad_div_ratio == QUAD_DIV_RATIO
      && clk_ctrl.sample_from_synth)
      else $error("fixed clock controls wrong");
   a_status_bits: assert property (
      s_rd(ADDR_SYNTH_STATUS) |=> reg_rdata[0] == $past(synth_status.lock)
      && reg_rdata[5:3] == {$past(synth_status.band_lo),
      $past(synth_status.band_hi), $past(synth_status.cal_ok)})
      else $error("synthesizer status read wrong");
   a_irq_bits: assert property (
      s_rd(ADDR_IRQ_STATUS) |=> (reg_rdata & ~IRQ_EVENT_MASK) == 8'h00)
      else $error("unused event bits read set");
   a_irq_off: assert property (
      s_wr(ADDR_IRQ_ENABLE) ##0 (reg_wdata & IRQ_EVENT_MASK) == 8'h00
      |-> ##2 !irq)
      else $error("interrupt with all events disabled");
   a_phase_clear: assert property (
      !lane_rx_enable[0] [*4] |-> lane_phase[PHASE_W-1:0] == '0)
      else $error("disabled lane phase not cleared");
endmodule

bind lane_clk_ctrl lane_clk_ctrl_checker #(.LANES(LANES), .PHASE_W(PHASE_W))
   u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata), .synth_status(synth_status),
   .lane_early(lane_early), .lane_late(lane_late), .clk_ctrl(clk_ctrl),
   .lane_rx_enable(lane_rx_enable), .lane_phase(lane_phase), .irq(irq));

// ### test/tb_lane_clk_ctrl.sv
// Self-checking bench for the lane clocking control block.
// Assumes the checker binds itself; the bench drives every input.
module tb_lane_clk_ctrl
   import lane_clk_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [11:0] RW[8] = '{ADDR_IRQ_ENABLE, ADDR_IF_POWER,
      ADDR_LANE_PD, ADDR_RECOV_RESET, ADDR_SAMPLING_MODE, ADDR_EQ_CONFIG,
      ADDR_SYNTH_CTRL, ADDR_SYNTH_DIV};
   localparam logic [1:0] DIVS[3] = '{DIV_CODE_BY1, DIV_CODE_BY2,
      DIV_CODE_BY4};
   localparam logic [7:0] MODES[3] = '{8'h02, 8'h00, 8'h20};
   // Recommended synthesizer tuning writes, address then value
   localparam logic [19:0] TUNE[15] = '{20'h28462, 20'h285C9, 20'h2860E,
      20'h28712, 20'h28A7B, 20'h28B00, 20'h29089, 20'h29424, 20'h29603,
      20'h2970D, 20'h29902, 20'h29A8E, 20'h29C2A, 20'h29F78, 20'h2A006};
   logic ref_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [11:0] reg_addr = 12'h000;
   logic [7:0] reg_wdata = 8'h00, lane_early = 8'h00, lane_late = 8'h00;
   logic [7:0] reg_rdata, lane_rx_enable, r;
   synth_status_t synth_status = 4'h0;
   clk_ctrl_t clk_ctrl;
   logic [47:0] lane_phase;
   logic irq;
   logic [1:0] rd_d = 2'b00;
   logic [15:0] q[$];
   logic [15:0] n;
   logic [5:0] ph[8];
   int num_errors = 0, num_checks = 0, seed = 73081, cnt;

   always #12.5 ref_clk = ~ref_clk;

   lane_clk_ctrl uut (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .synth_status(synth_status), .lane_early(lane_early),
      .lane_late(lane_late), .clk_ctrl(clk_ctrl),
      .lane_rx_enable(lane_rx_enable), .lane_phase(lane_phase), .irq(irq));

   // Comparison shared by the driver and the read watcher
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic w(input int k);
      repeat (k) @(posedge ref_clk);
      #2;
   endtask
   // Strobes last one cycle; an idle edge separates accesses
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      w(1);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      w(1);
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] e, m);
      w(1);
      reg_addr = a;
      reg_rd = 1'b1;
      q.push_back({m, e & m});
      w(1);
      reg_rd = 1'b0;
   endtask
   // The restart pulse is launched at the write edge, so look at once
   task automatic pulses(output int c);
      c = 0;
      repeat (4) begin
         c += clk_ctrl.cal_restart;
         w(1);
      end
   endtask
   task automatic finish_test;
      $display("checks=%0d errors=%0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // Read data lands one edge after the strobe; look mid-cycle after that
   always @(posedge ref_clk) rd_d <= {rd_d[0], reg_rd};
   always @(negedge ref_clk) begin
      if (rd_d[1]) begin
         n = q.pop_front();
         chk(reg_rdata & n[15:8], n[7:0]);
      end
   end

   // Watchdog sized well past the expected run of a few hundred cycles
   initial begin
      #500000;
      num_errors++;
      finish_test;
   end

   initial begin
      w(20);
      sys_rst = 1'b0;
      // Reset values, refused places, then read back of random writes
      for (int i = 0; i < 8; i++) rd(RW[i], {7'h0, RW[i] == ADDR_IF_POWER},
         8'hFF);
      rd(ADDR_IRQ_STATUS, 8'h00, 8'hFF);
      wr(12'h3FF, 8'hA5);
      rd(12'h3FF, 8'h00, 8'hFF);
      for (int i = 0; i < 8; i++) begin
         r = 8'($random(seed));
         wr(RW[i], r);
         rd(RW[i], r, 8'hFF);
         wr(RW[i], 8'h00);
      end
      $display("test registers done");
      // Live status through a read-only place that ignores writes
      wr(ADDR_SYNTH_STATUS, 8'hFF);
      repeat (3) begin
         r = 8'($random(seed));
         synth_status = r[3:0];
         rd(ADDR_SYNTH_STATUS,
            {2'b00, r[3:1], 2'b00, r[0]}, 8'h39);
      end
      synth_status = 4'h0;
      w(3);
      wr(ADDR_IRQ_STATUS, 8'h0C);
      rd(ADDR_IRQ_STATUS, 8'h00, 8'hFF);
      $display("test status done");
      // Lock and loss events: sticky, cleared one bit at a time, masked
      wr(ADDR_IRQ_ENABLE, 8'h0C);
      synth_status.lock = 1'b1;
      w(4);
      chk({7'h0, irq}, 8'h01);
      rd(ADDR_IRQ_STATUS, 8'h04, 8'hFF);
      synth_status.lock = 1'b0;
      w(4);
      rd(ADDR_IRQ_STATUS, 8'h0C, 8'hFF);
      wr(ADDR_IRQ_STATUS, 8'h04);
      rd(ADDR_IRQ_STATUS, 8'h08, 8'hFF);
      wr(ADDR_IRQ_ENABLE, 8'h04);
      w(2);
      chk({7'h0, irq}, 8'h00);
      wr(ADDR_IRQ_STATUS, 8'h08);
      rd(ADDR_IRQ_STATUS, 8'h00, 8'hFF);
      $display("test events done");
      // Divider and sampling mode per lane rate band, then enable
      foreach (TUNE[i]) wr(TUNE[i][19:8], TUNE[i][7:0]);
      for (int i = 0; i < 3; i++) begin
         wr(ADDR_SYNTH_DIV, {6'h00, DIVS[i]});
         wr(ADDR_SAMPLING_MODE, MODES[i]);
         w(2);
         chk({6'h00, clk_ctrl.divider_code}, {6'h00, DIVS[i]});
         chk({6'h00, clk_ctrl.half_rate_sampling_enable,
            clk_ctrl.double_oversampling_enable},
            {6'h00, MODES[i][5], MODES[i][1]});
      end
      chk({5'h00, clk_ctrl.quad_div_ratio, clk_ctrl.sample_from_synth},
         {5'h00, QUAD_DIV_RATIO, 1'b1});
      wr(ADDR_SYNTH_CTRL, 8'h01);
      wr(ADDR_SYNTH_CTRL, 8'h05);
      pulses(cnt);
      chk(cnt[7:0], 8'h01);
      wr(ADDR_SYNTH_CTRL, 8'h05);
      pulses(cnt);
      chk({cnt[6:0], clk_ctrl.synth_enable}, 8'h01);
      for (int f = 0; f < 4; f++) begin
         wr(ADDR_EQ_CONFIG, {f[1:0], 6'h00});
         w(2);
         chk({7'h0, clk_ctrl.eq_low_power}, {7'h0, f == 1});
      end
      $display("test clock controls done");
      // Lane power-down, interface power, recovery reset pulse
      r = 8'($random(seed));
      wr(ADDR_LANE_PD, r);
      w(2);
      chk(lane_rx_enable, ~r);
      wr(ADDR_IF_POWER, 8'h01);
      w(2);
      chk(lane_rx_enable, 8'h00);
      wr(ADDR_IF_POWER, 8'h00);
      wr(ADDR_LANE_PD, 8'h00);
      wr(ADDR_RECOV_RESET, 8'h01);
      w(2);
      chk({7'h0, clk_ctrl.recovery_reset}, 8'h01);
      wr(ADDR_RECOV_RESET, 8'h00);
      w(4);
      // Random votes per lane; each lane's phase must follow only its own
      ph = '{default: 6'h00};
      repeat (20) begin
         {lane_early, lane_late} = 16'($random(seed));
         for (int g = 0; g < 8; g++) begin
            if (lane_early[g] && !lane_late[g]) ph[g]--;
            else if (lane_late[g] && !lane_early[g]) ph[g]++;
         end
         w(1);
      end
      lane_early = 8'h00;
      lane_late = 8'h00;
      w(4);
      for (int g = 0; g < 8; g++) chk({2'b00, lane_phase[g*6 +: 6]},
         {2'b00, ph[g]});
      $display("test lanes done");
      finish_test;
   end
endmodule

// ### verilog/lane_clk_ctrl.sv
// Receive clocking control: synthesizer setup and status, recovery mode,
// lane power-down, equalizer mode and lock interrupt events.
// Assumes a byte-wide register port synchronous to ref_clk and analog
// status inputs already synchronous to ref_clk.
//
// Summary of operation
// R01: Software picks divider code 2, 1 or 0 by lane rate band.
// R02: Reference is lane rate over 40; divider keeps detector 35-80 MHz.
// R03: Software writes divider code first, then sets synthesizer enable.
// R04: Synthesizer lock reads as status bit 0.
// R05: Successful calibration reads as status bit 3.
// R06: Band limit flags on bits 4, 5; bit 2 low then high recalibrates.
// R07: Software should write fixed tuning values to the setup registers.
// R08: Lock and lock-lost events gated by interrupt enable bits 3:2.
// R09: Event status on interrupt status bits 3:2; writing ones clears them.
// R10: Software sets half-rate and oversampling bits by lane rate band.
// R11: Software pulses recovery reset bit 0 high then low after setup.
// R12: Mask bit set powers down that lane's receiver.
// R13: Equalizer field 01 selects low power, 00 normal operation.
// R14: Each lane's sampling phase is tracked independently.
// R15: Oscillator output divided by two feeds the deserializer cores.
// R16: Recovery sampling clocks come from the synthesizer, not the data.
// R17: Software clears interface power bit 0 before using the lanes.
// R18: Lock and lock-lost bits set on lock transitions, stay until cleared.
// R19: Interrupt output asserted while any enabled event bit is set.
module lane_clk_ctrl
   import lane_clk_pkg::*;
#(
   parameter int LANES = NUM_LANES,
   parameter int PHASE_W = PHASE_BITS
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [11:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire synth_status_t synth_status,
   input wire logic [LANES-1:0] lane_early,
   input wire logic [LANES-1:0] lane_late,
   output clk_ctrl_t clk_ctrl,
   output logic [LANES-1:0] lane_rx_enable,
   output logic [LANES*PHASE_W-1:0] lane_phase,
   output logic irq
);
   initial begin
      if (LANES < 1 || LANES > 8) $error("lane_clk_ctrl: LANES 1..8");
   end

   // Software visible registers
   logic [7:0] irq_enable_pll_reg, irq_enable_pll_next;
   logic [7:0] irq_status_pll_reg, irq_status_pll_next;
   logic [7:0] if_power_reg, if_power_next;
   logic [7:0] lane_powerdown_mask_reg, lane_powerdown_mask_next;
   logic [7:0] recovery_reset_control_reg, recovery_reset_control_next;
   logic [7:0] recovery_sampling_mode_reg, recovery_sampling_mode_next;
   logic [7:0] equalizer_config_reg, equalizer_config_next;
   logic [7:0] lane_synth_control_reg, lane_synth_control_next;
   logic [7:0] lane_synth_divider_reg, lane_synth_divider_next;
   logic [7:0] reg_rdata_reg, reg_rdata_next;
   logic lock_prev_reg, lock_prev_next;
   logic irq_reg, irq_next;
   clk_ctrl_t clk_ctrl_reg, clk_ctrl_next;
   logic [LANES-1:0] lane_rx_enable_reg, lane_rx_enable_next;
   logic [7:0] synth_status_byte;
   logic [7:0] event_set;
   logic [LANES*PHASE_W-1:0] phase_w;
   logic [LANES*PHASE_W-1:0] lane_phase_reg;

   // Status byte as software sees it
   always_comb begin
      synth_status_byte = RST_ZERO;
      synth_status_byte[BIT_LOCK] = synth_status.lock;       // [R04]
      synth_status_byte[BIT_CAL_OK] = synth_status.cal_ok;   // [R05]
      synth_status_byte[BIT_BAND_HI] = synth_status.band_hi; // [R06]
      synth_status_byte[BIT_BAND_LO] = synth_status.band_lo; // [R06]
   end

   // Lock edge events; a change of lock is an edge in either direction
   always_comb begin
      event_set = RST_ZERO;
      event_set[BIT_IRQ_LOCK] = synth_status.lock && !lock_prev_reg;  // [R18]
      event_set[BIT_IRQ_LOST] = !synth_status.lock && lock_prev_reg;  // [R18]
      lock_prev_next = synth_status.lock;
   end

   // Register writes and sticky status; a new event beats a clear
   always_comb begin
      irq_enable_pll_next = irq_enable_pll_reg;
      if_power_next = if_power_reg;
      lane_powerdown_mask_next = lane_powerdown_mask_reg;
      recovery_reset_control_next = recovery_reset_control_reg;
      recovery_sampling_mode_next = recovery_sampling_mode_reg;
      equalizer_config_next = equalizer_config_reg;
      lane_synth_control_next = lane_synth_control_reg;
      lane_synth_divider_next = lane_synth_divider_reg;
      irq_status_pll_next = irq_status_pll_reg;
      if (reg_wr) begin
         case (reg_addr)
            ADDR_IRQ_ENABLE: irq_enable_pll_next = reg_wdata;       // [R08]
            ADDR_IRQ_STATUS:
               irq_status_pll_next = irq_status_pll_reg & ~reg_wdata; // [R09]
            ADDR_IF_POWER: if_power_next = reg_wdata;
            ADDR_LANE_PD: lane_powerdown_mask_next = reg_wdata;
            ADDR_RECOV_RESET: recovery_reset_control_next = reg_wdata;
            ADDR_SAMPLING_MODE: recovery_sampling_mode_next = reg_wdata;
            ADDR_EQ_CONFIG: equalizer_config_next = reg_wdata;
            ADDR_SYNTH_CTRL: lane_synth_control_next = reg_wdata;
            ADDR_SYNTH_DIV: lane_synth_divider_next = reg_wdata;
            default: ;
         endcase
      end
      irq_status_pll_next = (irq_status_pll_next | event_set)
                            & IRQ_EVENT_MASK;                  // [R18]
   end

   // Read path; unmapped addresses read as zero
   always_comb begin
      reg_rdata_next = reg_rdata_reg;
      if (reg_rd) begin
         case (reg_addr)
            ADDR_IRQ_ENABLE: reg_rdata_next = irq_enable_pll_reg;
            ADDR_IRQ_STATUS: reg_rdata_next = irq_status_pll_reg; // [R09]
            ADDR_IF_POWER: reg_rdata_next = if_power_reg;
            ADDR_LANE_PD: reg_rdata_next = lane_powerdown_mask_reg;
            ADDR_RECOV_RESET: reg_rdata_next = recovery_reset_control_reg;
            ADDR_SAMPLING_MODE: reg_rdata_next = recovery_sampling_mode_reg;
            ADDR_EQ_CONFIG: reg_rdata_next = equalizer_config_reg;
            ADDR_SYNTH_CTRL: reg_rdata_next = lane_synth_control_reg;
            ADDR_SYNTH_STATUS: reg_rdata_next = synth_status_byte; // [R04]
            ADDR_SYNTH_DIV: reg_rdata_next = lane_synth_divider_reg;
            default: reg_rdata_next = RST_ZERO;
         endcase
      end
   end

   // Analog controls; recal pulse fires only on a 0 to 1 write of bit 2
   always_comb begin
      clk_ctrl_next.synth_enable = lane_synth_control_reg[BIT_SYNTH_EN];
      clk_ctrl_next.divider_code = lane_synth_divider_reg[1:0];
      clk_ctrl_next.cal_restart = lane_synth_control_next[BIT_SYNTH_RECAL]
         && !lane_synth_control_reg[BIT_SYNTH_RECAL];          // [R06]
      clk_ctrl_next.quad_div_ratio = QUAD_DIV_RATIO;           // [R15]
      clk_ctrl_next.recovery_reset =
         recovery_reset_control_reg[BIT_RECOV_RESET];
      clk_ctrl_next.half_rate_sampling_enable =
         recovery_sampling_mode_reg[BIT_HALF_RATE];
      clk_ctrl_next.double_oversampling_enable =
         recovery_sampling_mode_reg[BIT_OVERSAMPLE];
      clk_ctrl_next.sample_from_synth = 1'b1;                   // [R16]
      clk_ctrl_next.eq_low_power =
         (equalizer_config_reg[EQ_LSB+1:EQ_LSB] == EQ_LOW_POWER); // [R13]
      // Lane receivers also stay off while the whole interface is down
      lane_rx_enable_next = ~lane_powerdown_mask_reg[LANES-1:0]
         & {LANES{~if_power_reg[BIT_IF_PD]}};                   // [R12]
      irq_next = |(irq_status_pll_reg & irq_enable_pll_reg
                   & IRQ_EVENT_MASK);                           // [R19]
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         irq_enable_pll_reg <= RST_ZERO;
         irq_status_pll_reg <= RST_ZERO;
         if_power_reg <= RST_IF_POWER;
         lane_powerdown_mask_reg <= RST_ZERO;
         recovery_reset_control_reg <= RST_ZERO;
         recovery_sampling_mode_reg <= RST_ZERO;
         equalizer_config_reg <= RST_ZERO;
         lane_synth_control_reg <= RST_ZERO;
         lane_synth_divider_reg <= RST_ZERO;
         reg_rdata_reg <= RST_ZERO;
         lock_prev_reg <= 1'b0;
         irq_reg <= 1'b0;
         clk_ctrl_reg <= '0;
         lane_rx_enable_reg <= '0;
         lane_phase_reg <= '0;
      end else begin
         irq_enable_pll_reg <= irq_enable_pll_next;
         irq_status_pll_reg <= irq_status_pll_next;
         if_power_reg <= if_power_next;
         lane_powerdown_mask_reg <= lane_powerdown_mask_next;
         recovery_reset_control_reg <= recovery_reset_control_next;
         recovery_sampling_mode_reg <= recovery_sampling_mode_next;
         equalizer_config_reg <= equalizer_config_next;
         lane_synth_control_reg <= lane_synth_control_next;
         lane_synth_divider_reg <= lane_synth_divider_next;
         reg_rdata_reg <= reg_rdata_next;
         lock_prev_reg <= lock_prev_next;
         irq_reg <= irq_next;
         clk_ctrl_reg <= clk_ctrl_next;
         lane_rx_enable_reg <= lane_rx_enable_next;
         lane_phase_reg <= phase_w;
      end
   end

   // One tracker per lane, each free of the others' votes
   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : g_lane
         lane_phase_tracker #(
            .WIDTH(PHASE_W)
         ) u_track (
            .ref_clk(ref_clk),
            .sys_rst(sys_rst),
            .track_en(lane_rx_enable_reg[g]
                      && !clk_ctrl_reg.recovery_reset),          // [R14]
            .early(lane_early[g]),
            .late(lane_late[g]),
            .phase(phase_w[g*PHASE_W +: PHASE_W])
         );
      end
   endgenerate

   assign reg_rdata = reg_rdata_reg;
   assign clk_ctrl = clk_ctrl_reg;
   assign lane_rx_enable = lane_rx_enable_reg;
   assign lane_phase = lane_phase_reg;
   assign irq = irq_reg;
endmodule

// ### verilog/lane_clk_pkg.sv
// Shared constants and types for the lane receive clocking control block.
// Assumes an 8-bit register port with 12-bit addresses, one clock domain.
package lane_clk_pkg;
   // Register offsets
   localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h01F;
   localparam logic [11:0] ADDR_IRQ_STATUS = 12'h023;
   localparam logic [11:0] ADDR_IF_POWER = 12'h200;
   localparam logic [11:0] ADDR_LANE_PD = 12'h201;
   localparam logic [11:0] ADDR_RECOV_RESET = 12'h206;
   localparam logic [11:0] ADDR_SAMPLING_MODE = 12'h230;
   localparam logic [11:0] ADDR_EQ_CONFIG = 12'h268;
   localparam logic [11:0] ADDR_SYNTH_CTRL = 12'h280;
   localparam logic [11:0] ADDR_SYNTH_STATUS = 12'h281;
   localparam logic [11:0] ADDR_SYNTH_DIV = 12'h289;
   // Field positions
   localparam int BIT_SYNTH_EN = 0;
   localparam int BIT_SYNTH_RECAL = 2;
   localparam int BIT_LOCK = 0;
   localparam int BIT_CAL_OK = 3;
   localparam int BIT_BAND_HI = 4;
   localparam int BIT_BAND_LO = 5;
   localparam int BIT_IRQ_LOCK = 2;
   localparam int BIT_IRQ_LOST = 3;
   localparam int BIT_HALF_RATE = 5;
   localparam int BIT_OVERSAMPLE = 1;
   localparam int BIT_RECOV_RESET = 0;
   localparam int BIT_IF_PD = 0;
   localparam int EQ_LSB = 6;
   // Reset values and interrupt event mask
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_IF_POWER = 8'h01;
   localparam logic [7:0] IRQ_EVENT_MASK = 8'h0C;
   // Divider codes and equalizer settings
   localparam logic [1:0] DIV_CODE_BY4 = 2'h0;
   localparam logic [1:0] DIV_CODE_BY2 = 2'h1;
   localparam logic [1:0] DIV_CODE_BY1 = 2'h2;
   localparam logic [1:0] EQ_NORMAL = 2'h0;
   localparam logic [1:0] EQ_LOW_POWER = 2'h1;
   // Oscillator to quadrature clock ratio
   localparam logic [1:0] QUAD_DIV_RATIO = 2'h2;
   // Lane and phase sizes
   localparam int NUM_LANES = 8;
   localparam int PHASE_BITS = 6;

   // Synthesizer status from the analog loop
   typedef struct packed {
      logic band_lo;
      logic band_hi;
      logic cal_ok;
      logic lock;
   } synth_status_t;

   // Clock controls to the analog synthesizer and recovery circuits
   typedef struct packed {
      logic synth_enable;
      logic [1:0] divider_code;
      logic cal_restart;
      logic [1:0] quad_div_ratio;
      logic recovery_reset;
      logic half_rate_sampling_enable;
      logic double_oversampling_enable;
      logic sample_from_synth;
      logic eq_low_power;
   } clk_ctrl_t;
endpackage

// ### verilog/lane_phase_tracker.sv
// Sampling phase tracker for one serial lane.
// Assumes early/late votes from the lane's phase detector, one per clock.
module lane_phase_tracker
   import lane_clk_pkg::*;
#(
   parameter int WIDTH = PHASE_BITS
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic track_en,
   input wire logic early,
   input wire logic late,
   output logic [WIDTH-1:0] phase
);
   logic [WIDTH-1:0] phase_reg;
   logic [WIDTH-1:0] phase_next;

   initial begin
      if (WIDTH < 2) $error("lane_phase_tracker: WIDTH must be >= 2");
   end

   // Step the phase toward the data edge; conflicting votes hold still
   always_comb begin
      phase_next = phase_reg;
      if (!track_en) begin
         phase_next = '0;
      end else if (early && !late) begin
         phase_next = phase_reg - WIDTH'(1);
      end else if (late && !early) begin
         phase_next = phase_reg + WIDTH'(1);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         phase_reg <= '0;
      end else begin
         phase_reg <= phase_next;
      end
   end

   assign phase = phase_reg;
endmodule
